// ---- src/rmp_alias_remap.sv ----
// Alias match and address rewrite for control-bus pass-through
`include "rmp_map.svh"

module rmp_alias_remap (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  output logic reg_rvalid,
  input wire rmp_pkg::rmp_req_t req,
  output rmp_pkg::rmp_fwd_t fwd,
  output logic req_miss
);
  rmp_pkg::rmp_state_t st;
  rmp_pkg::rmp_state_t next_st;
  logic hit;
  logic [2:0] hit_idx;

  // Lowest index wins when two aliases hold the same address
  always_comb begin
    hit = 1'b0;
    hit_idx = 3'h0;
    for (int i = 7; i >= 0; i--) begin
      if (st.alias_addr[i] != `RMP_ADDR_OFF && st.target[i] != `RMP_ADDR_OFF
          && req.addr == st.alias_addr[i]) begin
        hit = 1'b1;
        hit_idx = 3'(i);
      end
    end
  end

  always_comb begin
    next_st = st;
    next_st.fwd.valid = 1'b0;
    next_st.miss = 1'b0;
    next_st.rvalid = 1'b0;
    if (req.valid && hit) begin
      next_st.fwd.valid = 1'b1;
      next_st.fwd.addr = st.target[hit_idx];
      next_st.fwd.index = hit_idx;
      next_st.fwd.rnw = req.rnw;
    end else if (req.valid) begin
      next_st.miss = 1'b1;
    end
    if (reg_wr) begin
      for (int i = 0; i < 8; i++) begin
        if (reg_addr == 8'(`RMP_TARGET_BASE + i)) begin
          next_st.target[i] = reg_wdata[`RMP_FIELD_MSB:`RMP_FIELD_LSB];
        end
        if (reg_addr == 8'(`RMP_ALIAS_BASE + i)) begin
          next_st.alias_addr[i] = reg_wdata[`RMP_FIELD_MSB:`RMP_FIELD_LSB];
        end
      end
    end
    if (reg_rd) begin
      next_st.rvalid = 1'b1;
      next_st.rdata = `RMP_UNMAPPED_READ;
      for (int i = 0; i < 8; i++) begin
        if (reg_addr == 8'(`RMP_TARGET_BASE + i)) begin
          next_st.rdata = {st.target[i], `RMP_RESERVED_BIT_READ};
        end
        if (reg_addr == 8'(`RMP_ALIAS_BASE + i)) begin
          next_st.rdata = {st.alias_addr[i], `RMP_RESERVED_BIT_READ};
        end
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign fwd = st.fwd;
  assign req_miss = st.miss;
  assign reg_rdata = st.rdata;
  assign reg_rvalid = st.rvalid;

  // Checker copies of the tables one cycle back
  rmp_pkg::rmp_addr_table_t prev_target;
  rmp_pkg::rmp_addr_table_t prev_alias;
  always_ff @(posedge clk_sys) begin
    prev_target <= st.target;
    prev_alias <= st.alias_addr;
  end

  reset_clear_a: assert property (@(posedge clk_sys)
    $fell(rst) |-> st.target[7] == `RMP_ADDR_RESET && st.alias_addr == '0)
    else $error("tables not cleared by reset");

  // Checker view: an enabled lower index would take the request first
  logic lower_claim;
  always_comb begin
    lower_claim = 1'b0;
    for (int j = 0; j < 7; j++) begin
      if (st.alias_addr[j] == req.addr && st.alias_addr[j] != `RMP_ADDR_OFF && st.target[j] != `RMP_ADDR_OFF) begin
        lower_claim = 1'b1;
      end
    end
  end

  alias_seven_hit_a: assert property (@(posedge clk_sys) disable iff (rst)
    req.valid && st.alias_addr[7] != `RMP_ADDR_OFF && st.target[7] != `RMP_ADDR_OFF
    && req.addr == st.alias_addr[7] && !lower_claim
    |=> fwd.valid && fwd.index == `RMP_SEVEN_INDEX && fwd.addr == $past(st.target[7]))
    else $error("alias seven not forwarded to target seven");

  zero_disables_a: assert property (@(posedge clk_sys) disable iff (rst)
    fwd.valid |-> prev_target[fwd.index] != `RMP_ADDR_OFF && prev_alias[fwd.index] != `RMP_ADDR_OFF)
    else $error("forward through a disabled index");

  alias_accept_a: assert property (@(posedge clk_sys) disable iff (rst)
    fwd.valid |-> $past(req.valid) && $past(req.addr) == prev_alias[fwd.index])
    else $error("forward without matching alias");

  rewrite_target_a: assert property (@(posedge clk_sys) disable iff (rst)
    fwd.valid |-> fwd.addr == prev_target[fwd.index] && fwd.rnw == $past(req.rnw))
    else $error("forwarded address is not the indexed target");

  remote_only_a: assert property (@(posedge clk_sys) disable iff (rst)
    req.valid |=> fwd.valid != req_miss)
    else $error("request neither forwarded nor refused");

  reserved_read_a: assert property (@(posedge clk_sys) disable iff (rst)
    reg_rd && reg_addr >= `RMP_TARGET_BASE && reg_addr <= `RMP_ALIAS_LAST
    |=> reg_rvalid && reg_rdata[0] == `RMP_RESERVED_BIT_READ)
    else $error("reserved bit read back nonzero");

  target_write_a: assert property (@(posedge clk_sys) disable iff (rst)
    reg_wr && reg_addr == `RMP_TARGET_SEVEN |=> st.target[7] == $past(reg_wdata[`RMP_FIELD_MSB:`RMP_FIELD_LSB]))
    else $error("target seven write lost");

  reset_outputs_a: assert property (@(posedge clk_sys)
    $fell(rst) |-> !fwd.valid && !req_miss && !reg_rvalid
      && reg_rdata == `RMP_UNMAPPED_READ && fwd.addr == `RMP_ADDR_RESET)
    else $error("outputs not cleared by reset");

  idle_no_forward_a: assert property (@(posedge clk_sys) disable iff (rst)
    !req.valid |=> !fwd.valid && !req_miss)
    else $error("answer without a request");

  zero_addr_miss_a: assert property (@(posedge clk_sys) disable iff (rst)
    req.valid && req.addr == `RMP_ADDR_OFF |=> req_miss && !fwd.valid)
    else $error("address zero was forwarded");

  miss_needs_req_a: assert property (@(posedge clk_sys) disable iff (rst)
    req_miss |-> $past(req.valid))
    else $error("refusal without a request");

  // Forward fields hold between hits so the channel can resample them
  fwd_hold_a: assert property (@(posedge clk_sys) disable iff (rst)
    !req.valid |=> $stable(fwd.addr) && $stable(fwd.index) && $stable(fwd.rnw))
    else $error("forward fields moved without a request");

  write_ignore_a: assert property (@(posedge clk_sys) disable iff (rst)
    reg_wr && (reg_addr < `RMP_TARGET_BASE || reg_addr > `RMP_ALIAS_LAST)
    |=> $stable(st.target) && $stable(st.alias_addr))
    else $error("unmapped write changed a table");

  // Read data stands until the next read
  rvalid_idle_a: assert property (@(posedge clk_sys) disable iff (rst)
    !reg_rd |=> !reg_rvalid)
    else $error("read valid without a read");

  rdata_hold_a: assert property (@(posedge clk_sys) disable iff (rst)
    !reg_rd |=> $stable(reg_rdata))
    else $error("read data moved without a read");

  unmapped_read_a: assert property (@(posedge clk_sys) disable iff (rst)
    reg_rd && (reg_addr < `RMP_TARGET_BASE || reg_addr > `RMP_ALIAS_LAST) |=> reg_rdata == `RMP_UNMAPPED_READ)
    else $error("unmapped read not zero");

  target_seven_read_a: assert property (@(posedge clk_sys) disable iff (rst)
    reg_rd && reg_addr == `RMP_TARGET_SEVEN |=> reg_rdata == {$past(st.target[7]), `RMP_RESERVED_BIT_READ})
    else $error("target seven read back wrong");

  // Aliases zero to four checked one by one
  alias_zero_write_a: assert property (@(posedge clk_sys) disable iff (rst)
    reg_wr && reg_addr == `RMP_ALIAS_ZERO |=> st.alias_addr[0] == $past(reg_wdata[`RMP_FIELD_MSB:`RMP_FIELD_LSB]))
    else $error("alias zero write lost");

  alias_one_write_a: assert property (@(posedge clk_sys) disable iff (rst)
    reg_wr && reg_addr == `RMP_ALIAS_ONE |=> st.alias_addr[1] == $past(reg_wdata[`RMP_FIELD_MSB:`RMP_FIELD_LSB]))
    else $error("alias one write lost");

  alias_two_write_a: assert property (@(posedge clk_sys) disable iff (rst)
    reg_wr && reg_addr == `RMP_ALIAS_TWO |=> st.alias_addr[2] == $past(reg_wdata[`RMP_FIELD_MSB:`RMP_FIELD_LSB]))
    else $error("alias two write lost");

  alias_three_write_a: assert property (@(posedge clk_sys) disable iff (rst)
    reg_wr && reg_addr == `RMP_ALIAS_THREE |=> st.alias_addr[3] == $past(reg_wdata[`RMP_FIELD_MSB:`RMP_FIELD_LSB]))
    else $error("alias three write lost");

  alias_four_write_a: assert property (@(posedge clk_sys) disable iff (rst)
    reg_wr && reg_addr == `RMP_ALIAS_FOUR |=> st.alias_addr[4] == $past(reg_wdata[`RMP_FIELD_MSB:`RMP_FIELD_LSB]))
    else $error("alias four write lost");

  alias_zero_read_a: assert property (@(posedge clk_sys) disable iff (rst)
    reg_rd && reg_addr == `RMP_ALIAS_ZERO |=> reg_rdata == {$past(st.alias_addr[0]), `RMP_RESERVED_BIT_READ})
    else $error("alias zero read back wrong");

  alias_one_read_a: assert property (@(posedge clk_sys) disable iff (rst)
    reg_rd && reg_addr == `RMP_ALIAS_ONE |=> reg_rdata == {$past(st.alias_addr[1]), `RMP_RESERVED_BIT_READ})
    else $error("alias one read back wrong");

  alias_two_read_a: assert property (@(posedge clk_sys) disable iff (rst)
    reg_rd && reg_addr == `RMP_ALIAS_TWO |=> reg_rdata == {$past(st.alias_addr[2]), `RMP_RESERVED_BIT_READ})
    else $error("alias two read back wrong");

  alias_three_read_a: assert property (@(posedge clk_sys) disable iff (rst)
    reg_rd && reg_addr == `RMP_ALIAS_THREE |=> reg_rdata == {$past(st.alias_addr[3]), `RMP_RESERVED_BIT_READ})
    else $error("alias three read back wrong");

  alias_four_read_a: assert property (@(posedge clk_sys) disable iff (rst)
    reg_rd && reg_addr == `RMP_ALIAS_FOUR |=> reg_rdata == {$past(st.alias_addr[4]), `RMP_RESERVED_BIT_READ})
    else $error("alias four read back wrong");
endmodule : rmp_alias_remap

// ---- src/rmp_map.svh ----
// Register offsets, field positions and reset values of the alias remap block
// Contract
// - Target seven holds address bits 7:1, resets zero
// - Alias seven hit forwards with target seven; code uses a lower index instead when an enabled lower alias also matches
// - Zero target or alias disables that index
// - Aliases hold 7:1, reset zero, match accepts
// - Accepted address rewritten to same-index target
// - Target addresses name remote slaves only
`ifndef RMP_MAP_SVH
`define RMP_MAP_SVH
`define RMP_TARGET_BASE 8'h08
`define RMP_TARGET_SEVEN 8'h0f
`define RMP_ALIAS_BASE 8'h10
`define RMP_ALIAS_ZERO 8'h10
`define RMP_ALIAS_ONE 8'h11
`define RMP_ALIAS_TWO 8'h12
`define RMP_ALIAS_THREE 8'h13
`define RMP_ALIAS_FOUR 8'h14
`define RMP_ALIAS_LAST 8'h17
`define RMP_FIELD_MSB 7
`define RMP_FIELD_LSB 1
`define RMP_ADDR_RESET 7'h00
`define RMP_ADDR_OFF 7'h00
`define RMP_RESERVED_BIT_READ 1'h0
`define RMP_UNMAPPED_READ 8'h00
`define RMP_SEVEN_INDEX 3'h7
`endif

// ---- src/rmp_pkg.sv ----
// Types shared by the alias remap block
package rmp_pkg;
  typedef logic [7:0][6:0] rmp_addr_table_t;

  typedef struct packed {
    logic valid;
    logic [6:0] addr;
    logic rnw;
  } rmp_req_t;

  typedef struct packed {
    logic valid;
    logic [6:0] addr;
    logic [2:0] index;
    logic rnw;
  } rmp_fwd_t;

  typedef struct packed {
    rmp_addr_table_t target;
    rmp_addr_table_t alias_addr;
    rmp_fwd_t fwd;
    logic miss;
    logic rvalid;
    logic [7:0] rdata;
  } rmp_state_t;
endpackage : rmp_pkg

// ---- bench/rmp_remote_model.sv ----
// Remote serializer stand-in: hands forwarded transactions to its slave
module rmp_remote_model (
  input wire logic clk_sys,
  input wire rmp_pkg::rmp_fwd_t fwd,
  output logic [6:0] slave_addr
);
  timeunit 1ns;
  timeprecision 1ps;
  initial slave_addr = 7'h00;
  always @(posedge clk_sys) if (fwd.valid) slave_addr <= fwd.addr;
endmodule : rmp_remote_model

// ---- bench/tb_rmp_alias_remap.sv ----
// Self-checking bench for the alias remap block
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin mismatches++; $display("MISMATCH %0t %h %h", $time, a, b); end end
module tb_rmp_alias_remap;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys, rst, reg_wr, reg_rd, reg_rvalid, req_miss, hit;
  logic [7:0] reg_addr, reg_wdata, reg_rdata;
  logic [6:0] slave_addr;
  logic [6:0] tgt [8] = '{default: 7'h00};
  logic [6:0] als [8] = '{default: 7'h00};
  rmp_pkg::rmp_req_t req;
  rmp_pkg::rmp_fwd_t fwd;
  int mismatches = 0, n_tests = 0, cyc = 0;
  rmp_alias_remap DUT (.clk_sys(clk_sys), .rst(rst), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .req(req), .fwd(fwd), .req_miss(req_miss));
  rmp_remote_model far (.clk_sys(clk_sys), .fwd(fwd), .slave_addr(slave_addr));
  task automatic close_out();
    if (mismatches == 0 && n_tests > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : close_out
  task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_sys);
    reg_wr = w;
    reg_rd = !w;
    reg_addr = a;
    reg_wdata = d;
    @(negedge clk_sys);
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  endtask : acc
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    acc(1'b1, a, d);
    if (a inside {[8'h08:8'h0f]}) tgt[a[2:0]] = d[7:1];
    if (a inside {[8'h10:8'h17]}) als[a[2:0]] = d[7:1];
  endtask : wr
  task automatic rd(input logic [7:0] a);
    logic [7:0] e;
    e = 8'h00;
    if (a inside {[8'h08:8'h0f]}) e = {tgt[a[2:0]], 1'b0};
    if (a inside {[8'h10:8'h17]}) e = {als[a[2:0]], 1'b0};
    acc(1'b0, a, 8'h00);
    `CHK(reg_rvalid, 1'b1)
    `CHK(reg_rdata, e)
  endtask : rd
  task automatic send(input logic [6:0] a, input logic r);
    int k;
    k = 8;
    for (int i = 7; i >= 0; i--) if (a != 7'h00 && als[i] == a && tgt[i] != 7'h00) k = i;
    hit = k < 8;
    @(negedge clk_sys);
    req = '{1'b1, a, r};
    @(negedge clk_sys);
    req.valid = 1'b0;
    `CHK(fwd.valid, hit)
    `CHK(req_miss, !hit)
    if (hit) begin
      `CHK({fwd.addr, fwd.index, fwd.rnw}, {tgt[k[2:0]], k[2:0], r})
      @(negedge clk_sys);
      `CHK(slave_addr, tgt[k[2:0]])
    end
  endtask : send
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    // Whole run needs about nine hundred cycles
    if (cyc == 5000) begin
      mismatches++;
      close_out();
    end
  end
  initial begin
    rst = 1'b1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    req = '0;
    void'($urandom(19));
    repeat (12) @(negedge clk_sys);
    rst = 1'b0;
    for (int a = 6; a < 26; a++) rd(8'(a));
    for (int i = 0; i < 8; i++) begin
      wr(8'(8'h08 + i), 8'($urandom));
      // Top bits carry the index so aliases never coincide
      wr(8'(8'h10 + i), {3'(i), 4'($urandom), 1'b1});
    end
    wr(8'h0a, 8'h01);
    wr(8'h15, 8'h00);
    wr(8'h1c, 8'hff);
    for (int a = 6; a < 26; a++) rd(8'(a));
    repeat (150) begin
      send(als[$urandom_range(0, 7)], 1'($urandom));
      send(7'($urandom), 1'($urandom));
    end
    // Mid-run reset must clear both tables again
    @(negedge clk_sys);
    rst = 1'b1;
    repeat (2) @(negedge clk_sys);
    rst = 1'b0;
    tgt = '{default: 7'h00};
    als = '{default: 7'h00};
    `CHK({fwd, req_miss, reg_rvalid, reg_rdata}, 22'h0)
    for (int a = 15; a < 21; a++) rd(8'(a));
    send(7'($urandom), 1'b1);
    close_out();
  end
endmodule : tb_rmp_alias_remap
